/* dv/lag_assertions.sv */
// Checker of port timing for the link aggregation distributor.
module lag_checker
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic regRd,
   input wire logic [lag_pkg::REG_DATA_W-1:0] regRdData,
   input wire logic [lag_pkg::NUM_MEMBERS-1:0] linkUpPin,
   input wire logic frameValid,
   input wire logic egressValid,
   input wire logic [lag_pkg::MEMBER_IDX_W-1:0] egressMember,
   input wire logic egressDrop,
   input wire logic [lag_pkg::NUM_BUNDLES-1:0] bundleUp,
   input wire logic [lag_pkg::NUM_MEMBERS-1:0] memberForwarding
);
   timeunit 1ns;
   timeprecision 1ps;
   import lag_pkg::*;
   logic [NUM_MEMBERS-1:0] prevFwd;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////
   // Members live at the request edge, kept for the answer cycle.
   always_ff @(posedge clk)
   begin
      if (clkEn)
         prevFwd <= memberForwarding;
   end
   // A taken frame and an empty set of members are the two causes.
   sequence frameReq;
      clkEn && frameValid;
   endsequence
   sequence noMember;
      memberForwarding == '0;
   endsequence
   a_egress_follows_frame: assert property (frameReq |=> egressValid)
      else $error("no egress answer after a frame");
   a_egress_no_request: assert property (clkEn && !frameValid |=> !egressValid)
      else $error("egress answer without a frame");
   a_drop_when_empty: assert property (frameReq and noMember |=> egressDrop)
      else $error("frame not dropped with no live member");
   a_pick_live_member: assert property (egressValid && !egressDrop |-> prevFwd[egressMember])
      else $error("egress member was not operational");
   a_member_held: assert property (clkEn && !frameValid |=> $stable(egressMember))
      else $error("egress member changed between frames");
   a_drop_with_answer: assert property (egressDrop |-> egressValid)
      else $error("drop flag without egress answer");
   a_up_means_member: assert property ((bundleUp == '0) == (memberForwarding == '0))
      else $error("bundle state disagrees with members");
   a_read_data_idle: assert property (clkEn && !regRd |=> regRdData == '0)
      else $error("read data outside the answer cycle");
   a_link_loss_stops: assert property ((linkUpPin == '0) [*4] |-> noMember)
      else $error("member forwards with its link down");
endmodule // lag_checker

bind link_aggregation_distributor lag_checker chk (.clk, .nrst, .clkEn, .regRd, .regRdData,
   .linkUpPin, .frameValid, .egressValid, .egressMember, .egressDrop, .bundleUp,
   .memberForwarding);

/* dv/link_aggregation_distributor_bench.sv */
// Self-checking bench of the link aggregation distributor.
module link_aggregation_distributor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import lag_pkg::*;
   localparam logic [23:0] ATTR = 24'h00_1203;
   localparam logic [31:0] PCFG = {ATTR, 8'h04};
   localparam logic [7:0] PORT3 = REG_PORT_CFG_BASE + 8'h0C;
   // Rows: mode, IP frame, multicast, then which fields are varied.
   localparam logic [8:0] ROWS [10] = '{9'h00D, 9'h04E, 9'h08C, 9'h0E7, 9'h12B,
      9'h163, 9'h0C1, 9'h033, 9'h1A3, 9'h18C};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0000_0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdData;
   logic [3:0] linkUpPin, fullDuplexPin, memberForwarding, bundleUp;
   logic [3:0] linkCmd = 4'h0;
   logic [3:0] badSpeed = 4'h0;
   logic [7:0] speedPin;
   logic frameValid = 1'b0;
   logic [47:0] frameSrcMac = '0;
   logic [47:0] frameDstMac = '0;
   logic [31:0] frameSrcIp = '0;
   logic [31:0] frameDstIp = '0;
   logic [15:0] frameSrcL4 = '0;
   logic [15:0] frameDstL4 = '0;
   logic frameIsIp = 1'b0;
   logic frameHasL4 = 1'b0;
   logic frameRouted = 1'b0;
   logic frameMulticast = 1'b0;
   logic egressValid, egressDrop;
   logic [1:0] egressMember;
   logic clkEn = 1'b1;
   logic [1:0] frameBundle = 2'b00;
   logic [47:0] bundleMac;
   int errTotal = 0;
   int totalChecks = 0;
   ////////////////////////////////////////////////////////////
   // Free-running clock of 10 ns.
   always #5 clk = ~clk;
   link_aggregation_distributor DUT (.clk, .nrst, .clkEn, .regAddr, .regWrData,
      .regWr, .regRd, .regRdData, .linkUpPin, .fullDuplexPin, .speedPin, .frameValid,
      .frameSrcMac, .frameDstMac, .frameSrcIp, .frameDstIp, .frameSrcL4, .frameDstL4,
      .frameIsIp, .frameHasL4, .frameRouted, .frameMulticast, .frameBundle,
      .egressValid, .egressMember, .egressDrop, .bundleUp, .memberForwarding,
      .bundleMac);
   link_partner_model partner (.clk, .linkCmd, .badSpeed, .linkUpPin, .fullDuplexPin,
      .speedPin);
   // Every comparison goes through here so the counts stay honest.
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         errTotal++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Bus cycles: one strobe cycle each, data sampled in the answer cycle.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      check(48'(regRdData), 48'(exp));
   endtask
   // One frame descriptor; the answer is read one cycle later.
   task automatic send(input logic [47:0] sm, dm, input logic [31:0] si, di,
      input logic ip, mc, output logic [1:0] mem);
      @(posedge clk);
      frameValid <= 1'b1;
      frameSrcMac <= sm;
      frameDstMac <= dm;
      frameSrcIp <= si;
      frameDstIp <= di;
      frameSrcL4 <= si[15:0];
      frameDstL4 <= di[15:0];
      frameIsIp <= ip;
      frameHasL4 <= ip & ~mc;
      frameRouted <= ip;
      frameMulticast <= mc;
      @(posedge clk);
      frameValid <= 1'b0;
      #1;
      check(48'(egressValid), 48'h1);
      mem = egressMember;
   endtask
   // Link pins cross two sync stages, so allow a few edges.
   task automatic settle;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic tallyAndFinish;
      $display("checks %0d mismatches %0d", totalChecks, errTotal);
      if (errTotal == 0 && totalChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // A hang would stop well past the roughly two hundred cycles used.
   initial
   begin
      repeat (20000) @(posedge clk);
      errTotal++;
      tallyAndFinish;
   end
   // Main sequence of tests.
   initial
   begin
      logic [8:0] row;
      logic [1:0] memA, memB;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rdChk(REG_GLOBAL_CTRL, 32'(LB_DEFAULT));
      check(48'(bundleUp), 48'h0);
      linkCmd <= 4'hF;
      wr(REG_BUNDLE_CFG_BASE, {ATTR, 8'h00});
      for (int p = 0; p < 4; p++)
         wr(REG_PORT_CFG_BASE + 8'(4 * p), PCFG);
      settle;
      rdChk(REG_BUNDLE_STATUS, 32'h0000_001F);
      rdChk(REG_MEMBER_STATE, 32'h0000_00AA);
      wr(PORT3, {ATTR ^ 24'h00_0100, 8'h04});
      settle;
      rdChk(REG_MEMBER_STATE, 32'h0000_006A);
      wr(PORT3, {ATTR ^ 24'h00_0100, 8'h0C});
      settle;
      rdChk(REG_MEMBER_STATE, 32'h0000_00AA);
      wr(PORT3, {ATTR ^ 24'h00_0001, 8'h0C});
      settle;
      rdChk(REG_MEMBER_STATE, 32'h0000_006A);
      wr(PORT3, {ATTR, 8'h14});
      settle;
      check(48'(memberForwarding), 48'h7);
      wr(PORT3, PCFG);
      badSpeed <= 4'h8;
      settle;
      check(48'(memberForwarding), 48'h7);
      badSpeed <= 4'h0;
      settle;
      check(48'(memberForwarding), 48'hF);
      // Fields outside the mode must not move a flow to another member.
      for (int r = 0; r < 10; r++)
      begin
         row = ROWS[r];
         wr(REG_GLOBAL_CTRL, {29'h0, row[8:6]});
         send(48'h0011_2233_4455, 48'h0066_7788_99AA, 32'h0A01_0203, 32'h0A04_0506,
            row[5], row[4], memA);
         send(48'h0011_2233_4455 ^ {48{row[0]}}, 48'h0066_7788_99AA ^ {48{row[1]}},
            32'h0A01_0203 ^ {32{row[2]}}, 32'h0A04_0506 ^ {32{row[3]}}, row[5], row[4],
            memB);
         check(48'(memB), 48'(memA));
         check(48'(egressDrop), 48'h0);
      end
      linkCmd <= 4'h8;
      settle;
      check(48'(memberForwarding), 48'h8);
      for (int k = 0; k < 4; k++)
      begin
         send(48'(k), 48'h0000_0000_0100, 32'(k), 32'h0A00_0001, 1'b0, 1'b0, memA);
         check(48'(memA), 48'h3);
      end
      check(48'(bundleUp), 48'h1);
      // A frame for an empty bundle must not borrow a member of another one.
      frameBundle <= 2'b01;
      send(48'h5, 48'h6, 32'h7, 32'h8, 1'b0, 1'b0, memA);
      check(48'(egressDrop), 48'h1);
      frameBundle <= 2'b00;
      linkCmd <= 4'h0;
      settle;
      rdChk(REG_BUNDLE_STATUS, 32'h0000_0000);
      send(48'h1, 48'h2, 32'h3, 32'h4, 1'b0, 1'b0, memA);
      check(48'(egressDrop), 48'h1);
      wr(REG_STATIC_MAC_LO, 32'h89AB_CDEF);
      wr(REG_STATIC_MAC_HI, 32'h0000_0123);
      rdChk(REG_STATIC_MAC_LO, 32'h89AB_CDEF);
      rdChk(REG_STATIC_MAC_HI, 32'h0000_0123);
      rdChk(8'h80, UNMAPPED_READ);
      // A write while the clock enable is low must leave the register alone.
      clkEn <= 1'b0;
      wr(REG_STATIC_MAC_LO, 32'h0000_0000);
      clkEn <= 1'b1;
      rdChk(REG_STATIC_MAC_LO, 32'h89AB_CDEF);
      wr(REG_ROUTER_MAC_LO, 32'h7654_3210);
      wr(REG_ROUTER_MAC_HI, 32'h0000_0FED);
      check(bundleMac, 48'h0);
      linkCmd <= 4'hF;
      settle;
      check(48'(memberForwarding), 48'hF);
      check(bundleMac, 48'h0FED_7654_3210);
      wr(REG_GLOBAL_CTRL, 32'h0000_0106);
      settle;
      check(bundleMac, 48'h0123_89AB_CDEF);
      wr(REG_GLOBAL_CTRL, 32'h0000_0046);
      settle;
      rdChk(REG_MEMBER_STATE, 32'h0000_0000);
      check(48'(bundleUp), 48'h0);
      tallyAndFinish;
   end
endmodule // link_aggregation_distributor_bench

/* dv/link_partner_model.sv */
// Model of the neighbouring switch ports that face the member links.
module link_partner_model
(
   input wire logic clk,
   input wire logic [lag_pkg::NUM_MEMBERS-1:0] linkCmd,
   input wire logic [lag_pkg::NUM_MEMBERS-1:0] badSpeed,
   output logic [lag_pkg::NUM_MEMBERS-1:0] linkUpPin,
   output logic [lag_pkg::NUM_MEMBERS-1:0] fullDuplexPin,
   output logic [2*lag_pkg::NUM_MEMBERS-1:0] speedPin
);
   timeunit 1ns;
   timeprecision 1ps;
   import lag_pkg::*;
   typedef struct packed
   {
      logic [NUM_MEMBERS-1:0] up;
      logic [2*NUM_MEMBERS-1:0] speed;
   } pins_t;
   pins_t pins;
   pins_t next_pins;
   ////////////////////////////////////////////////////////////
   // Four links at one speed; a bad speed is only set on command.
   always_comb
   begin
      next_pins.up = linkCmd;
      for (int p = 0; p < NUM_MEMBERS; p++)
         next_pins.speed[2*p +: 2] = badSpeed[p] ? 2'b01 : 2'b10;
   end
   // Pins move only after a clock edge, like a real far end.
   always_ff @(posedge clk)
   begin
      pins <= next_pins;
   end
   assign linkUpPin = pins.up;
   assign speedPin = pins.speed;
   assign fullDuplexPin = '1;
endmodule // link_partner_model

/* rtl/lag_pkg.sv */
// Package with constants and types shared by the link aggregation distributor.
package lag_pkg;
   localparam int NUM_MEMBERS = 4;
   localparam int MEMBER_IDX_W = 2;
   localparam int NUM_BUNDLES = 4;
   localparam int BUNDLE_ID_W = 2;
   localparam int REG_ADDR_W = 8;
   localparam int REG_DATA_W = 32;
   localparam int HASH_W = 16;

   // Register byte addresses.
   localparam logic [REG_ADDR_W-1:0] REG_GLOBAL_CTRL = 8'h00;
   localparam logic [REG_ADDR_W-1:0] REG_BUNDLE_STATUS = 8'h04;
   localparam logic [REG_ADDR_W-1:0] REG_MEMBER_STATE = 8'h08;
   localparam logic [REG_ADDR_W-1:0] REG_STATIC_MAC_LO = 8'h0C;
   localparam logic [REG_ADDR_W-1:0] REG_STATIC_MAC_HI = 8'h10;
   localparam logic [REG_ADDR_W-1:0] REG_PORT_CFG_BASE = 8'h20;
   localparam logic [REG_ADDR_W-1:0] REG_BUNDLE_CFG_BASE = 8'h40;
   localparam logic [REG_ADDR_W-1:0] REG_ROUTER_MAC_LO = 8'h60;
   localparam logic [REG_ADDR_W-1:0] REG_ROUTER_MAC_HI = 8'h64;
   localparam logic [REG_ADDR_W-1:0] REG_PORT_CFG_MASK = 8'hF0;
   localparam logic [REG_ADDR_W-1:0] REG_ENTRY_MASK = 8'h0C;
   localparam int REG_ENTRY_LSB = 2;

   // Port configuration word fields.
   localparam int PC_BUNDLE_LSB = 0;
   localparam int PC_JOIN_BIT = 2;
   localparam int PC_FORCE_BIT = 3;
   localparam int PC_CHMODE_LSB = 4;
   localparam int PC_ATTR_LSB = 8;
   localparam int ATTR_W = 24;

   // Attribute word layout: flow-control pair in the low two bits.
   localparam logic [ATTR_W-1:0] ATTR_FLOWCTL_MASK = 24'h00_0003;

   // Global control fields, then the bundle configuration protocol bit.
   localparam int GC_MODE_LSB = 0;
   localparam int GC_MODE_W = 3;
   localparam int GC_DELETE_LSB = 4;
   localparam int GC_MACVALID_BIT = 8;
   localparam int BC_PROTO_BIT = 0;

   localparam logic [REG_DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      CH_ON = 2'b00,
      CH_ACTIVE = 2'b01,
      CH_PASSIVE = 2'b10,
      CH_RESERVED = 2'b11
   } chan_mode_t;

   typedef enum logic [2:0]
   {
      LB_DST_MAC = 3'b000,
      LB_SRC_MAC = 3'b001,
      LB_SRC_DST_MAC = 3'b010,
      LB_DST_IP = 3'b011,
      LB_SRC_IP = 3'b100,
      LB_SRC_DST_IP = 3'b101,
      LB_DEFAULT = 3'b110
   } lb_mode_t;

   typedef enum logic [1:0]
   {
      MS_DETACHED = 2'b00,
      MS_SUSPENDED = 2'b01,
      MS_CHANNELING = 2'b10
   } member_state_t;
endpackage

/* rtl/link_aggregation_distributor.sv */
// Link aggregation logic: member admission, bundle state and egress selection.
module link_aggregation_distributor
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic [lag_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [lag_pkg::REG_DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [lag_pkg::REG_DATA_W-1:0] regRdData,
   input wire logic [lag_pkg::NUM_MEMBERS-1:0] linkUpPin,
   input wire logic [lag_pkg::NUM_MEMBERS-1:0] fullDuplexPin,
   input wire logic [2*lag_pkg::NUM_MEMBERS-1:0] speedPin,
   input wire logic frameValid,
   input wire logic [47:0] frameSrcMac,
   input wire logic [47:0] frameDstMac,
   input wire logic [31:0] frameSrcIp,
   input wire logic [31:0] frameDstIp,
   input wire logic [15:0] frameSrcL4,
   input wire logic [15:0] frameDstL4,
   input wire logic frameIsIp,
   input wire logic frameHasL4,
   input wire logic frameRouted,
   input wire logic frameMulticast,
   input wire logic [lag_pkg::BUNDLE_ID_W-1:0] frameBundle,
   output logic egressValid,
   output logic [lag_pkg::MEMBER_IDX_W-1:0] egressMember,
   output logic egressDrop,
   output logic [lag_pkg::NUM_BUNDLES-1:0] bundleUp,
   output logic [lag_pkg::NUM_MEMBERS-1:0] memberForwarding,
   output logic [47:0] bundleMac
);
   import lag_pkg::*;

   typedef struct packed
   {
      logic [NUM_MEMBERS-1:0][ATTR_W-1:0] portAttr;
      logic [NUM_MEMBERS-1:0][BUNDLE_ID_W-1:0] portBundle;
      logic [NUM_MEMBERS-1:0] portJoin;
      logic [NUM_MEMBERS-1:0] portForce;
      logic [NUM_MEMBERS-1:0][1:0] portChMode;
      logic [NUM_BUNDLES-1:0][ATTR_W-1:0] bundleAttr;
      logic [NUM_BUNDLES-1:0] bundleLacp;
      logic [GC_MODE_W-1:0] lbMode;
      logic staticMacValid;
      logic [47:0] staticMac;
      logic [47:0] routerMac;
      logic [NUM_MEMBERS-1:0][1:0] memberState;
      logic macLatched;
      logic [REG_DATA_W-1:0] rdData;
      logic egValid;
      logic [MEMBER_IDX_W-1:0] egMember;
      logic egDrop;
      logic [47:0] bMac;
   } state_t;

   state_t cur;
   state_t next_cur;

   // Pin inputs pass two flip-flops before any logic reads them.
   logic [NUM_MEMBERS-1:0] linkMeta;
   logic [NUM_MEMBERS-1:0] linkSync;
   logic [NUM_MEMBERS-1:0] duplexMeta;
   logic [NUM_MEMBERS-1:0] duplexSync;
   logic [2*NUM_MEMBERS-1:0] speedMeta;
   logic [2*NUM_MEMBERS-1:0] speedSync;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         linkMeta <= '0;
         linkSync <= '0;
         duplexMeta <= '0;
         duplexSync <= '0;
         speedMeta <= '0;
         speedSync <= '0;
      end
      else if (clkEn)
      begin
         linkMeta <= linkUpPin;
         linkSync <= linkMeta;
         duplexMeta <= fullDuplexPin;
         duplexSync <= duplexMeta;
         speedMeta <= speedPin;
         speedSync <= speedMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-member admission checks.
   logic [NUM_MEMBERS-1:0] compatible;
   logic [NUM_MEMBERS-1:0] admitted;
   logic [NUM_MEMBERS-1:0] operational;
   logic [NUM_MEMBERS-1:0] onlyOwnerOk;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_MEMBERS; gi++)
      begin : g_member
         logic attrMatch;
         logic fcMatch;
         logic modeOk;
         logic linkOk;
         logic [BUNDLE_ID_W-1:0] bid;
         logic leaderOk;
         logic leaderSeen;
         // Speed and duplex are compared against the lowest joined member of the
         // bundle, so an odd port other than that lowest one is suspended alone and the rest keep running.
         always_comb
         begin
            bid = cur.portBundle[gi];
            attrMatch = (cur.portAttr[gi] == cur.bundleAttr[bid]);
            fcMatch = ((cur.portAttr[gi] & ATTR_FLOWCTL_MASK) ==
                       (cur.bundleAttr[bid] & ATTR_FLOWCTL_MASK));
            if (cur.bundleLacp[bid])
               modeOk = (cur.portChMode[gi] == CH_ACTIVE) ||
                        (cur.portChMode[gi] == CH_PASSIVE);
            else
               modeOk = (cur.portChMode[gi] == CH_ON);
            leaderOk = 1'b1;
            leaderSeen = 1'b0;
            for (int j = 0; j < NUM_MEMBERS; j++)
            begin
               if (!leaderSeen && cur.portJoin[j] && (cur.portBundle[j] == bid))
               begin
                  leaderSeen = 1'b1;
                  if ((speedSync[2*j +: 2] != speedSync[2*gi +: 2]) ||
                      (duplexSync[j] != duplexSync[gi]))
                     leaderOk = 1'b0;
               end
            end
            linkOk = linkSync[gi];
         end
         // All four members form one quad, so bundling never crosses quads.
         assign onlyOwnerOk[gi] = 1'b1;
         assign compatible[gi] = modeOk && leaderOk && onlyOwnerOk[gi] &&
                                 (attrMatch || (cur.portForce[gi] && fcMatch));
         assign admitted[gi] = cur.portJoin[gi] && compatible[gi];
         assign operational[gi] = admitted[gi] && linkOk &&
                                  (cur.memberState[gi] == MS_CHANNELING);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Hash key selection and member choice for the frame.
   lb_mode_t mode;
   logic useSrc;
   logic useDst;
   logic [HASH_W-1:0] hashVal;
   logic [NUM_MEMBERS-1:0] bundleOper;
   logic [2:0] operCount;
   logic [2:0] pickIdx;
   logic [MEMBER_IDX_W-1:0] chosen;
   logic chosenFound;

   function automatic logic [HASH_W-1:0] fold48(input logic [47:0] v);
      fold48 = v[47:32] ^ v[31:16] ^ v[15:0];
   endfunction

   function automatic logic [HASH_W-1:0] fold32(input logic [31:0] v);
      fold32 = v[31:16] ^ v[15:0];
   endfunction

   always_comb
   begin
      mode = lb_mode_t'(cur.lbMode);
      useSrc = 1'b1;
      useDst = 1'b1;
      hashVal = '0;
      // The configured mode names a direction; family follows the frame.
      unique case (mode)
         LB_DST_MAC, LB_DST_IP: useSrc = 1'b0;
         LB_SRC_MAC, LB_SRC_IP: useDst = 1'b0;
         default: ;
      endcase
      if (frameMulticast && frameIsIp && !frameHasL4)
         hashVal = fold32(frameSrcIp) ^ fold32(frameDstIp);
      else if (frameMulticast && !frameIsIp)
         hashVal = fold48(frameSrcMac) ^ fold48(frameDstMac);
      else if (mode == LB_DEFAULT)
      begin
         // Reset default: routed IP uses both addresses plus ports.
         if (frameRouted && frameIsIp)
            hashVal = fold32(frameSrcIp) ^ fold32(frameDstIp) ^ frameSrcL4 ^ frameDstL4;
         else
            hashVal = fold48(frameSrcMac) ^ fold48(frameDstMac);
      end
      else if (frameIsIp)
         hashVal = (useSrc ? fold32(frameSrcIp) : '0) ^ (useDst ? fold32(frameDstIp) : '0);
      else
         hashVal = (useSrc ? fold48(frameSrcMac) : '0) ^ (useDst ? fold48(frameDstMac) : '0);
   end

   // Only live members of the addressed bundle count, so a failed link's
   // flows spread across the survivors on the very next frame.
   always_comb
   begin
      operCount = '0;
      for (int k = 0; k < NUM_MEMBERS; k++)
      begin
         bundleOper[k] = operational[k] && (cur.portBundle[k] == frameBundle);
         operCount = operCount + {2'b00, bundleOper[k]};
      end
      pickIdx = (operCount == '0) ? 3'b000 : 3'(hashVal % 16'(operCount));
      chosen = '0;
      chosenFound = 1'b0;
      for (int k = NUM_MEMBERS - 1; k >= 0; k--)
      begin
         logic [2:0] rank;
         rank = '0;
         for (int m = 0; m < k; m++)
            rank = rank + {2'b00, bundleOper[m]};
         if (bundleOper[k] && (rank == pickIdx))
         begin
            chosen = MEMBER_IDX_W'(k);
            chosenFound = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic: register access, member states and egress outputs.
   always_comb
   begin
      logic [NUM_MEMBERS-1:0] anyFirstUp;
      logic [1:0] idx;
      logic [BUNDLE_ID_W-1:0] delId;
      next_cur = cur;
      idx = regAddr[REG_ENTRY_LSB +: 2];
      anyFirstUp = '0;
      delId = regWrData[GC_DELETE_LSB +: BUNDLE_ID_W];
      next_cur.rdData = UNMAPPED_READ;

      if (regWr)
      begin
         if (regAddr == REG_GLOBAL_CTRL)
         begin
            next_cur.lbMode = regWrData[GC_MODE_LSB +: GC_MODE_W];
            next_cur.staticMacValid = regWrData[GC_MACVALID_BIT];
            // Delete strobe: members fall back as if removed one by one.
            if (regWrData[GC_DELETE_LSB + BUNDLE_ID_W])
            begin
               for (int k = 0; k < NUM_MEMBERS; k++)
               begin
                  if (cur.portBundle[k] == delId)
                  begin
                     next_cur.portJoin[k] = 1'b0;
                     next_cur.portForce[k] = 1'b0;
                  end
               end
            end
         end
         else if (regAddr == REG_STATIC_MAC_LO)
            next_cur.staticMac[31:0] = regWrData;
         else if (regAddr == REG_STATIC_MAC_HI)
            next_cur.staticMac[47:32] = regWrData[15:0];
         else if (regAddr == REG_ROUTER_MAC_LO)
            next_cur.routerMac[31:0] = regWrData;
         else if (regAddr == REG_ROUTER_MAC_HI)
            next_cur.routerMac[47:32] = regWrData[15:0];
         else if ((regAddr & REG_PORT_CFG_MASK) == REG_PORT_CFG_BASE)
         begin
            // One bundle field per port enforces single membership.
            next_cur.portBundle[idx] = regWrData[PC_BUNDLE_LSB +: BUNDLE_ID_W];
            next_cur.portJoin[idx] = regWrData[PC_JOIN_BIT];
            next_cur.portForce[idx] = regWrData[PC_FORCE_BIT];
            next_cur.portChMode[idx] = regWrData[PC_CHMODE_LSB +: 2];
            next_cur.portAttr[idx] = regWrData[PC_ATTR_LSB +: ATTR_W];
         end
         else if ((regAddr & REG_PORT_CFG_MASK) == REG_BUNDLE_CFG_BASE)
         begin
            next_cur.bundleLacp[idx] = regWrData[BC_PROTO_BIT];
            next_cur.bundleAttr[idx] = regWrData[PC_ATTR_LSB +: ATTR_W];
         end
      end

      if (regRd)
      begin
         if (regAddr == REG_GLOBAL_CTRL)
            next_cur.rdData = REG_DATA_W'({cur.staticMacValid, 5'b0_0000, cur.lbMode});
         else if (regAddr == REG_BUNDLE_STATUS)
            next_cur.rdData = REG_DATA_W'({bundleUp, memberForwarding});
         else if (regAddr == REG_MEMBER_STATE)
            next_cur.rdData = REG_DATA_W'(cur.memberState);
         else if (regAddr == REG_STATIC_MAC_LO)
            next_cur.rdData = cur.staticMac[31:0];
         else if (regAddr == REG_STATIC_MAC_HI)
            next_cur.rdData = REG_DATA_W'(cur.staticMac[47:32]);
         else if (regAddr == REG_ROUTER_MAC_LO)
            next_cur.rdData = cur.routerMac[31:0];
         else if (regAddr == REG_ROUTER_MAC_HI)
            next_cur.rdData = REG_DATA_W'(cur.routerMac[47:32]);
         else if ((regAddr & REG_PORT_CFG_MASK) == REG_PORT_CFG_BASE)
            next_cur.rdData = {cur.portAttr[idx], 2'b00, cur.portChMode[idx],
                               cur.portForce[idx], cur.portJoin[idx], cur.portBundle[idx]};
         else if ((regAddr & REG_PORT_CFG_MASK) == REG_BUNDLE_CFG_BASE)
            next_cur.rdData = {cur.bundleAttr[idx], 7'b000_0000, cur.bundleLacp[idx]};
      end

      // Member state follows join and compatibility, not link; suspended members never forward.
      for (int k = 0; k < NUM_MEMBERS; k++)
      begin
         if (!cur.portJoin[k])
            next_cur.memberState[k] = MS_DETACHED;
         else if (!compatible[k])
            next_cur.memberState[k] = MS_SUSPENDED;
         else
            next_cur.memberState[k] = MS_CHANNELING;
         anyFirstUp[k] = operational[k];
      end

      // Bundle MAC is the static MAC when valid, else the router MAC latched once a member first comes up.
      if (cur.staticMacValid)
         next_cur.bMac = cur.staticMac;
      else if (!cur.macLatched && (anyFirstUp != '0))
      begin
         next_cur.bMac = cur.routerMac;
         next_cur.macLatched = 1'b1;
      end
      else if (anyFirstUp == '0)
         next_cur.macLatched = 1'b0;

      next_cur.egValid = frameValid;
      next_cur.egMember = frameValid ? chosen : cur.egMember;
      next_cur.egDrop = frameValid && !chosenFound;
   end

   // Reset loads the default distribution mode and an empty configuration.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cur <= '0;
         cur.lbMode <= LB_DEFAULT;
      end
      else if (clkEn)
         cur <= next_cur;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   always_comb
   begin
      for (int b = 0; b < NUM_BUNDLES; b++)
      begin
         bundleUp[b] = 1'b0;
         for (int k = 0; k < NUM_MEMBERS; k++)
            if (operational[k] && (cur.portBundle[k] == BUNDLE_ID_W'(b)))
               bundleUp[b] = 1'b1;
      end
   end

   assign memberForwarding = operational;
   assign regRdData = cur.rdData;
   assign egressValid = cur.egValid;
   assign egressMember = cur.egMember;
   assign egressDrop = cur.egDrop;
   assign bundleMac = cur.bMac;
endmodule // link_aggregation_distributor
